// ===== core/ppr_router.sv
/*
  Peripheral pin router: places each peripheral's pin signals on a
  default pin, an alternative pin or on no pin, as the route registers
  select, and returns pin levels to the peripherals.
  Assumes peripheral signals are on pclk; pin levels are asynchronous.
*/
// Local design decision: register access over APB.
`timescale 1ns/100ps
// Contract
// RULE1 - Software enables, disables or moves pin groups
// RULE2 - Event B on B2, or B7 when set
// RULE3 - Event A on A2, or A7 when set
// RULE4 - Table 3 output C4 or A5
// RULE5 - Table 2 output B3 or B6
// RULE6 - Table 1 output A7 or C1
// RULE7 - Table 0 output A4 or B4
// RULE8 - Serial 1: A1-A4, C2/C1/C0/C3, or none
// RULE9 - Event, table, serial routes reset to zero
// RULE10 - Serial 0: B2/B3/B1/B0, A1-A4, or none
// RULE11 - SPI: A1-A4, C2/C1/C0/C3, or none
// RULE12 - Each wide timer output moves independently
// RULE13 - Capture timers move to C4 and C0
// RULE14 - Unused bits read zero, reserved connects nothing
module ppr_router
(
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ppr_pkg::PPR_AW-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Event outputs
  input  wire logic [1:0]                   evo_out,
  input  wire logic [1:0]                   evo_en,
  // Logic tables
  input  wire logic [3:0]                   lut_out,
  input  wire logic [3:0]                   lut_en,
  output logic      [3:0][2:0]              lut_in,
  // Serial ports and SPI; lanes: data out, data in, clock, direction/select
  input  wire logic [3:0]                   ser0_out,
  input  wire logic [3:0]                   ser0_drv,
  output logic      [3:0]                   ser0_in,
  input  wire logic [3:0]                   ser1_out,
  input  wire logic [3:0]                   ser1_drv,
  output logic      [3:0]                   ser1_in,
  input  wire logic [3:0]                   spi_out,
  input  wire logic [3:0]                   spi_drv,
  output logic      [3:0]                   spi_in,
  // Timers
  input  wire logic [5:0]                   wtm_wo,
  input  wire logic [5:0]                   wtm_en,
  input  wire logic [1:0]                   ctm_wo,
  input  wire logic [1:0]                   ctm_en,
  // Port pins
  input  wire logic [ppr_pkg::PPR_NPIN-1:0] pin_level,
  output logic      [ppr_pkg::PPR_NPIN-1:0] pin_out,
  output logic      [ppr_pkg::PPR_NPIN-1:0] pin_own
);
  import ppr_pkg::*;

  ppr_route_if rt ();

  logic [PPR_NPIN-1:0] pin_sync;
  logic [PPR_NPIN-1:0] out_q;
  logic [PPR_NPIN-1:0] out_d;
  logic [PPR_NPIN-1:0] own_q;
  logic [PPR_NPIN-1:0] own_d;
  logic [2:0][3:0]     grp_in_q;
  logic [2:0][3:0]     grp_in_d;
  logic [3:0][2:0]     lut_in_q;
  logic [3:0][2:0]     lut_in_d;
  logic [2:0][3:0]     grp_out;
  logic [2:0][3:0]     grp_drv;
  logic [2:0][1:0]     grp_fld;

  ppr_regs u_regs
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rt      (rt.regs)
  );

  ppr_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_level),
    .q       (pin_sync)
  );

  function automatic ppr_pin_t ppr_pick(input logic alt, input ppr_pin_t dp, input ppr_pin_t ap);
    return alt ? ap : dp;
  endfunction : ppr_pick

  // Only the default and alternative codes connect; reserved behaves as none
  function automatic logic ppr_on(input logic [1:0] f);
    return f == PPR_POS_DEFAULT || f == PPR_POS_ALT; // RULE14
  endfunction : ppr_on

  assign grp_out = {spi_out, ser1_out, ser0_out};
  assign grp_drv = {spi_drv, ser1_drv, ser0_drv};
  assign grp_fld = {rt.spi, rt.ser[PPR_SER1_LSB +: 2], rt.ser[PPR_SER0_LSB +: 2]};

  // Later claims win a pin: timers lowest, event outputs highest. Software
  // should avoid overlaps; the fixed order only keeps the pin defined.
  always_comb
  begin
    ppr_pin_t p;
    p        = '0;
    own_d    = '0;
    out_d    = '0;
    grp_in_d = '0;
    lut_in_d = '0;
    for (int i = 0; i < 2; i++)
    begin
      p = ppr_pick(rt.ctm[i], PPR_CTM_DEF[i], PPR_CTM_ALT[i]); // RULE13
      if (ctm_en[i])
      begin
        own_d[p] = 1'b1;
        out_d[p] = ctm_wo[i];
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      p = ppr_pick(rt.wtm[i], PPR_WTM_DEF[i], PPR_WTM_ALT[i]); // RULE12
      if (wtm_en[i])
      begin
        own_d[p] = 1'b1;
        out_d[p] = wtm_wo[i];
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      p = ppr_pick(rt.lut[k], PPR_LUT_DEF[k], PPR_LUT_ALT[k]); // RULE4 RULE5 RULE6 RULE7
      if (lut_en[k])
      begin
        own_d[p] = 1'b1;
        out_d[p] = lut_out[k];
      end
      for (int j = 0; j < 3; j++)
        lut_in_d[k][j] = pin_sync[PPR_LUT_IN[k][j]];
    end
    for (int g = 2; g >= 0; g--)
    begin
      for (int i = 0; i < 4; i++)
      begin
        p = ppr_pick(grp_fld[g] == PPR_POS_ALT, PPR_GRP_DEF[g][i], PPR_GRP_ALT[g][i]);
        if (ppr_on(grp_fld[g])) // RULE8 RULE10 RULE11
        begin
          grp_in_d[g][i] = pin_sync[p];
          if (grp_drv[g][i])
          begin
            own_d[p] = 1'b1;
            out_d[p] = grp_out[g][i];
          end
        end
      end
    end
    for (int i = 0; i < 2; i++)
    begin
      p = ppr_pick(rt.evo[i], PPR_EVO_DEF[i], PPR_EVO_ALT[i]); // RULE2 RULE3
      if (evo_en[i])
      begin
        own_d[p] = 1'b1;
        out_d[p] = evo_out[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q    <= '0;
      own_q    <= '0;
      grp_in_q <= '0;
      lut_in_q <= '0;
    end
    else
    begin
      out_q    <= out_d;
      own_q    <= own_d;
      grp_in_q <= grp_in_d;
      lut_in_q <= lut_in_d;
    end
  end

  assign pin_out = out_q;
  assign pin_own = own_q;
  assign rt.own  = own_q;
  assign ser0_in = grp_in_q[0];
  assign ser1_in = grp_in_q[1];
  assign spi_in  = grp_in_q[2];
  assign lut_in  = lut_in_q;

  AST_EVO_B_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    ($past(evo_en[1]) && $past(rt.evo[1]))
      |-> pin_own[PPR_EVO_ALT[1]] && pin_out[PPR_EVO_ALT[1]] == $past(evo_out[1]))
    else $error("event output B not on its alternative pin");

  AST_EVO_A_DEF: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    ($past(evo_en[0]) && !$past(rt.evo[0]))
      |-> pin_own[PPR_EVO_DEF[0]] && pin_out[PPR_EVO_DEF[0]] == $past(evo_out[0]))
    else $error("event output A not on its default pin");

  AST_LOGIC_TABLE_3_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    ($past(lut_en[3]) && $past(rt.lut[3])) |-> pin_own[PPR_LUT_ALT[3]])
    else $error("table 3 output not on its alternative pin");

  AST_LOGIC_TABLE_2_DEF: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    ($past(lut_en[2]) && !$past(rt.lut[2])) |-> pin_own[PPR_LUT_DEF[2]])
    else $error("table 2 output not on its default pin");

  AST_LOGIC_TABLE_1_IN: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    lut_in[1][0] == $past(pin_level[PPR_LUT_IN[1][0]], 3))
    else $error("table 1 input 0 not taken from its fixed pin");

  AST_LOGIC_TABLE_0_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    ($past(lut_en[0]) && $past(rt.lut[0])) |-> pin_own[PPR_LUT_ALT[0]])
    else $error("table 0 output not on its alternative pin");

  AST_SER1_NONE: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    ($past(rt.ser[PPR_SER1_LSB +: 2]) == PPR_POS_NONE) |-> ser1_in == 4'h0)
    else $error("serial port 1 sees a pin while disconnected");

  AST_SER0_RX: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    ($past(rt.ser[PPR_SER0_LSB +: 2]) == PPR_POS_DEFAULT)
      |-> ser0_in[1] == $past(pin_level[PPR_GRP_DEF[0][1]], 3))
    else $error("serial port 0 receive not from its default pin");

  AST_SPI_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    ($past(rt.spi) == PPR_POS_ALT && $past(spi_drv[2])) |-> pin_own[PPR_GRP_ALT[2][2]])
    else $error("SPI clock not on its alternative pin");

  AST_WTM4_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ($past(wtm_en[4]) && $past(rt.wtm[4])) |-> pin_own[PPR_WTM_ALT[4]])
    else $error("wide timer output 4 not on its alternative pin");

  AST_CTM1_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    ($past(ctm_en[1]) && $past(rt.ctm[1])) |-> pin_own[PPR_CTM_ALT[1]])
    else $error("capture timer 1 not on its alternative pin");

  AST_SPI_RSV: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    ($past(rt.spi) == PPR_POS_RSV) |-> spi_in == 4'h0)
    else $error("SPI connected under a reserved code");

  AST_OWN_DROP: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (own_d == '0) |=> pin_own == '0 && pin_out == '0)
    else $error("pin kept after every claim was withdrawn");

  AST_EVO_B_DEF: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    ($past(evo_en[1]) && !$past(rt.evo[1]))
      |-> pin_own[PPR_EVO_DEF[1]] && pin_out[PPR_EVO_DEF[1]] == $past(evo_out[1]))
    else $error("event output B not on its default pin");

  AST_EVO_A_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    ($past(evo_en[0]) && $past(rt.evo[0]))
      |-> pin_own[PPR_EVO_ALT[0]] && pin_out[PPR_EVO_ALT[0]] == $past(evo_out[0]))
    else $error("event output A not on its alternative pin");

  AST_LOGIC_TABLE_3_DEF: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    ($past(lut_en[3]) && !$past(rt.lut[3])) |-> pin_own[PPR_LUT_DEF[3]])
    else $error("table 3 output not on its default pin");

  AST_LOGIC_TABLE_2_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    ($past(lut_en[2]) && $past(rt.lut[2])) |-> pin_own[PPR_LUT_ALT[2]])
    else $error("table 2 output not on its alternative pin");

  AST_LOGIC_TABLE_1_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    ($past(lut_en[1]) && $past(rt.lut[1])) |-> pin_own[PPR_LUT_ALT[1]])
    else $error("table 1 output not on its alternative pin");

  AST_LOGIC_TABLE_0_DEF: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    ($past(lut_en[0]) && !$past(rt.lut[0])) |-> pin_own[PPR_LUT_DEF[0]])
    else $error("table 0 output not on its default pin");

  AST_SER1_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    ($past(rt.ser[PPR_SER1_LSB +: 2]) == PPR_POS_ALT && $past(ser1_drv[0]))
      |-> pin_own[PPR_GRP_ALT[1][0]])
    else $error("serial port 1 transmit not on its alternative pin");

  AST_SER0_NONE: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    ($past(rt.ser[PPR_SER0_LSB +: 2]) == PPR_POS_NONE) |-> ser0_in == 4'h0)
    else $error("serial port 0 sees a pin while disconnected");

  AST_SPI_NONE: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    ($past(rt.spi) == PPR_POS_NONE) |-> spi_in == 4'h0)
    else $error("SPI sees a pin while disconnected");

  AST_WTM0_DEF: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    ($past(wtm_en[0]) && !$past(rt.wtm[0])) |-> pin_own[PPR_WTM_DEF[0]])
    else $error("wide timer output 0 not on its default pin");

  AST_CTM0_ALT: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    ($past(ctm_en[0]) && $past(rt.ctm[0])) |-> pin_own[PPR_CTM_ALT[0]])
    else $error("capture timer 0 not on its alternative pin");

  AST_SER1_RSV: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    ($past(rt.ser[PPR_SER1_LSB +: 2]) == PPR_POS_RSV) |-> ser1_in == 4'h0)
    else $error("serial port 1 connected under a reserved code");
endmodule : ppr_router

// ===== core/ppr_pkg.sv
/*
  Constants and types for the peripheral pin router: register indices,
  writable masks, reset value, field codes and pin position tables.
  Assumes pins are numbered {port, pin}: port A = 0, B = 1, C = 2.
*/
package ppr_pkg;

  // Pin index: bits 4:3 select the port, bits 2:0 the pin within it
  typedef logic [4:0] ppr_pin_t;

  typedef enum logic [1:0]
  {
    PPR_POS_DEFAULT = 2'h0,
    PPR_POS_ALT     = 2'h1,
    PPR_POS_RSV     = 2'h2,
    PPR_POS_NONE    = 2'h3
  } ppr_pos_t;

  localparam int         PPR_NPIN     = 24;
  localparam int         PPR_AW       = 12;
  localparam int         PPR_NROUTE   = 6;
  localparam logic [3:0] PPR_IDX_EVO  = 4'h0;
  localparam logic [3:0] PPR_IDX_LUT  = 4'h1;
  localparam logic [3:0] PPR_IDX_SER  = 4'h2;
  localparam logic [3:0] PPR_IDX_SPI  = 4'h3;
  localparam logic [3:0] PPR_IDX_WTM  = 4'h4;
  localparam logic [3:0] PPR_IDX_CTM  = 4'h5;
  localparam logic [3:0] PPR_IDX_OWNA = 4'h6;
  localparam logic [3:0] PPR_IDX_OWNC = 4'h8;
  localparam logic [7:0] PPR_RST      = 8'h00;
  localparam int         PPR_SER0_LSB = 0;
  localparam int         PPR_SER1_LSB = 2;

  localparam logic [7:0] PPR_MSK [PPR_NROUTE] = '{8'h03, 8'h0F, 8'h0F, 8'h03, 8'h3F, 8'h03};

  localparam ppr_pin_t PPR_EVO_DEF [2] = '{5'h02, 5'h0A};
  localparam ppr_pin_t PPR_EVO_ALT [2] = '{5'h07, 5'h0F};
  localparam ppr_pin_t PPR_LUT_DEF [4] = '{5'h04, 5'h07, 5'h0B, 5'h14};
  localparam ppr_pin_t PPR_LUT_ALT [4] = '{5'h0C, 5'h11, 5'h0E, 5'h05};
  localparam ppr_pin_t PPR_LUT_IN [4][3] = '{'{5'h00, 5'h01, 5'h02}, '{5'h13, 5'h14, 5'h15},
                                             '{5'h08, 5'h09, 5'h0A}, '{5'h10, 5'h11, 5'h12}};
  // Groups: 0 serial port 0, 1 serial port 1, 2 SPI port 0
  localparam ppr_pin_t PPR_GRP_DEF [3][4] = '{'{5'h0A, 5'h0B, 5'h09, 5'h08},
                                              '{5'h01, 5'h02, 5'h03, 5'h04},
                                              '{5'h01, 5'h02, 5'h03, 5'h04}};
  localparam ppr_pin_t PPR_GRP_ALT [3][4] = '{'{5'h01, 5'h02, 5'h03, 5'h04},
                                              '{5'h12, 5'h11, 5'h10, 5'h13},
                                              '{5'h12, 5'h11, 5'h10, 5'h13}};
  localparam ppr_pin_t PPR_WTM_DEF [6] = '{5'h08, 5'h09, 5'h0A, 5'h03, 5'h04, 5'h05};
  localparam ppr_pin_t PPR_WTM_ALT [6] = '{5'h0B, 5'h0C, 5'h0D, 5'h13, 5'h14, 5'h15};
  localparam ppr_pin_t PPR_CTM_DEF [2] = '{5'h05, 5'h03};
  localparam ppr_pin_t PPR_CTM_ALT [2] = '{5'h10, 5'h14};

endpackage : ppr_pkg

// ===== core/ppr_route_if.sv
/*
  Route settings from the register file to the routing core, and the
  pin ownership state back for read-out.
  Assumes both ends share pclk.
*/
`timescale 1ns/100ps
interface ppr_route_if;
  import ppr_pkg::*;
  logic [1:0]          evo;
  logic [3:0]          lut;
  logic [3:0]          ser;
  logic [1:0]          spi;
  logic [5:0]          wtm;
  logic [1:0]          ctm;
  logic [PPR_NPIN-1:0] own;

  modport regs (output evo, lut, ser, spi, wtm, ctm, input own);
  modport core (input evo, lut, ser, spi, wtm, ctm, output own);
endinterface : ppr_route_if

// ===== core/ppr_sync.sv
/*
  Two-stage synchroniser for the pin input levels.
  Assumes pin levels are asynchronous to pclk.
*/
`timescale 1ns/100ps
module ppr_sync
(
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // Levels
  input  wire logic [ppr_pkg::PPR_NPIN-1:0] d,
  output logic      [ppr_pkg::PPR_NPIN-1:0] q
);
  import ppr_pkg::*;

  logic [PPR_NPIN-1:0] meta_q;
  logic [PPR_NPIN-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : ppr_sync

// ===== core/ppr_regs.sv
/*
  APB register file: six route registers and three read-only pin
  ownership registers. Zero wait states.
  Assumes an APB master; byte address is four times the register index.
*/
`timescale 1ns/100ps
module ppr_regs
(
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ppr_pkg::PPR_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Route settings
  ppr_route_if.regs                       rt
);
  import ppr_pkg::*;

  logic [PPR_NROUTE-1:0][7:0] route_q;
  logic [PPR_NROUTE-1:0][7:0] route_d;
  logic [31:0]                prdata_q;
  logic [31:0]                prdata_d;
  logic                       seen_wr_q;
  logic                       seen_wr_d;
  logic [3:0]                 idx;
  logic                       access;

  function automatic logic ppr_mapped(input logic [PPR_AW-1:0] a);
    return a[1:0] == 2'h0 && a[PPR_AW-1:6] == '0 && a[5:2] <= PPR_IDX_OWNC;
  endfunction : ppr_mapped

  assign idx    = paddr[5:2];
  assign access = psel && penable;

  always_comb
  begin
    route_d   = route_q;
    prdata_d  = prdata_q;
    seen_wr_d = seen_wr_q;
    // Unimplemented bits are masked on write so they always read zero
    if (access && pwrite && ppr_mapped(paddr) && idx <= PPR_IDX_CTM) // RULE14
    begin
      route_d[idx[2:0]] = pwdata[7:0] & PPR_MSK[idx[2:0]]; // RULE1
      seen_wr_d         = 1'b1;
    end
    // Read data is captured in setup so that it comes from a flip-flop
    if (psel && !penable)
    begin
      prdata_d = 32'h0000_0000;
      if (ppr_mapped(paddr))
      begin
        if (idx <= PPR_IDX_CTM)
          prdata_d[7:0] = route_q[idx[2:0]];
        else
          prdata_d[7:0] = rt.own[8*(idx-PPR_IDX_OWNA) +: 8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      route_q   <= {PPR_NROUTE{PPR_RST}}; // RULE9
      prdata_q  <= 32'h0000_0000;
      seen_wr_q <= 1'b0;
    end
    else
    begin
      route_q   <= route_d;
      prdata_q  <= prdata_d;
      seen_wr_q <= seen_wr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access && !ppr_mapped(paddr);
  assign rt.evo  = route_q[PPR_IDX_EVO[2:0]][1:0];
  assign rt.lut  = route_q[PPR_IDX_LUT[2:0]][3:0];
  assign rt.ser  = route_q[PPR_IDX_SER[2:0]][3:0];
  assign rt.spi  = route_q[PPR_IDX_SPI[2:0]][1:0];
  assign rt.wtm  = route_q[PPR_IDX_WTM[2:0]][5:0];
  assign rt.ctm  = route_q[PPR_IDX_CTM[2:0]][1:0];

  AST_RST_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    !seen_wr_q |-> (rt.evo == 2'h0 && rt.lut == 4'h0 && rt.ser == 4'h0))
    else $error("route register left its reset value without a write");

  AST_WR_STEERS: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (access && pwrite && paddr == {6'h00, PPR_IDX_WTM, 2'h0}) |=> rt.wtm == $past(pwdata[5:0]))
    else $error("timer route write not taken");
endmodule : ppr_regs

// ===== tb/ppr_pin_model.sv
/*
  Pin-side partner: each pin reads back the router's drive where the
  router owns it, and the board level elsewhere.
  Assumes ideal pads with no drive fights.
*/
`timescale 1ns/100ps
module ppr_pin_model
(
  // Router side
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_own,
  // Board side
  input  wire logic [23:0] ext_level,
  output logic      [23:0] pin_level
);
  // Owned pins loop back so the router hears its own drive
  assign pin_level = (pin_own & pin_out) | (~pin_own & ext_level);
endmodule : ppr_pin_model

// ===== tb/ppr_router_tb.sv
/*
  Self-checking bench for the pin router: APB tasks, route table cases
  and pin input checks.
  Assumes zero-wait APB, one-cycle pin output and three-cycle pin input latency as handed over.
*/
`timescale 1ns/100ps
module ppr_router_tb;
  import ppr_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [16:0]        src;
  logic               lvl;
  logic [3:0][2:0]    lut_in;
  logic [3:0]         ser0_in, ser1_in, spi_in;
  logic [PPR_NPIN-1:0] pin_level, pin_out, pin_own, ext;
  int                 mismatches, cmp_count;
  localparam int WDEF [6] = '{8, 9, 10, 3, 4, 5};
  localparam int WALT [6] = '{11, 12, 13, 19, 20, 21};
  localparam int LIN [12] = '{0, 1, 2, 19, 20, 21, 8, 9, 10, 16, 17, 18};

  ppr_router i_ppr_router
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evo_out(src[1:0] & {2{lvl}}), .evo_en(src[1:0]),
    .lut_out(src[5:2] & {4{lvl}}), .lut_en(src[5:2]), .lut_in(lut_in),
    .ser0_out({3'h0, src[6] & lvl}), .ser0_drv({3'h0, src[6]}), .ser0_in(ser0_in),
    .ser1_out({3'h0, src[7] & lvl}), .ser1_drv({3'h0, src[7]}), .ser1_in(ser1_in),
    .spi_out({3'h0, src[8] & lvl}), .spi_drv({3'h0, src[8]}), .spi_in(spi_in),
    .wtm_wo(src[14:9] & {6{lvl}}), .wtm_en(src[14:9]),
    .ctm_wo(src[16:15] & {2{lvl}}), .ctm_en(src[16:15]),
    .pin_level(pin_level), .pin_out(pin_out), .pin_own(pin_own)
  );

  ppr_pin_model i_ppr_pin_model
  (
    .pin_out(pin_out), .pin_own(pin_own), .ext_level(ext), .pin_level(pin_level)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Starts one edge in, so a release and the next setup never share a step
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    check("pslverr", {31'h0, pslverr}, {31'h0, a > 12'h20 || a[1:0] != 2'h0});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task route_case(input int idx, input logic [7:0] v, input int s, input int pin);
    logic [31:0] exp;
    apb(1'b1, 12'(idx * 4), {24'h0, v});
    src <= 17'h1 << s;
    lvl <= ~lvl;
    repeat (2) @(posedge pclk);
    #1;
    exp = (pin < 0) ? 32'h0 : 32'h1 << pin;
    check("pin_own", {8'h0, pin_own}, exp);
    check("pin_out", {8'h0, pin_out}, lvl ? exp : 32'h0);
  endtask : route_case

  task in_case(input logic [7:0] v, input int pin, input logic [3:0] e0, input logic [3:0] e1);
    apb(1'b1, 12'h008, {24'h0, v});
    ext <= 24'h1 << pin;
    repeat (4) @(posedge pclk);
    #1;
    check("ser0_in", {28'h0, ser0_in}, {28'h0, e0});
    check("ser1_in", {28'h0, ser1_in}, {28'h0, e1});
  endtask : in_case

  initial
  begin
    #200000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    {psel, penable, pwrite, lvl} = 4'h0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    src     = 17'h0;
    ext     = 24'h0;
    presetn = 1'b0;
    mismatches = 0;
    cmp_count  = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    check("pin_own", {8'h0, pin_own}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'(i * 4), 32'hFFFF_FFFF);
      apb(1'b0, 12'(i * 4), 32'h0);
      check("masked readback", rd, 32'(PPR_MSK[i]));
    end
    apb(1'b1, 12'h040, 32'hFFFF_FFFF);
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped read", rd, 32'h0);
    apb(1'b1, 12'h001, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check("misaligned write", rd, 32'(PPR_MSK[0]));
    $display("test registers done");
    route_case(0, 8'h00, 0, 2);
    route_case(0, 8'h01, 0, 7);
    route_case(0, 8'h00, 1, 10);
    route_case(0, 8'h02, 1, 15);
    route_case(1, 8'h00, 2, 4);
    route_case(1, 8'h01, 2, 12);
    route_case(1, 8'h00, 3, 7);
    route_case(1, 8'h02, 3, 17);
    route_case(1, 8'h00, 4, 11);
    route_case(1, 8'h04, 4, 14);
    route_case(1, 8'h00, 5, 20);
    route_case(1, 8'h08, 5, 5);
    route_case(2, 8'h00, 6, 10);
    route_case(2, 8'h01, 6, 1);
    route_case(2, 8'h03, 6, -1);
    route_case(2, 8'h02, 6, -1);
    route_case(2, 8'h03, 7, 1);
    route_case(2, 8'h04, 7, 18);
    route_case(2, 8'h08, 7, -1);
    route_case(2, 8'h0C, 7, -1);
    route_case(3, 8'h00, 8, 1);
    route_case(3, 8'h01, 8, 18);
    route_case(3, 8'h03, 8, -1);
    route_case(3, 8'h02, 8, -1);
    for (int k = 0; k < 6; k++)
    begin
      route_case(4, 8'h1 << k, 9 + k, WALT[k]);
      route_case(4, 8'h3F ^ (8'h1 << k), 9 + k, WDEF[k]);
    end
    route_case(5, 8'h00, 15, 5);
    route_case(5, 8'h01, 15, 16);
    route_case(5, 8'h00, 16, 3);
    route_case(5, 8'h02, 16, 20);
    apb(1'b1, 12'h010, 32'h0);
    src <= 17'h07E00;
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    apb(1'b0, 12'h018, 32'h0);
    check("port A owners", rd, 32'h38);
    apb(1'b0, 12'h01C, 32'h0);
    check("port B owners", rd, 32'h07);
    apb(1'b0, 12'h020, 32'h0);
    check("port C owners", rd, 32'h0);
    $display("test outputs done");
    src <= 17'h0;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge pclk);
      ext <= 24'h1 << LIN[i];
      repeat (4) @(posedge pclk);
      #1;
      check("lut_in", {20'h0, lut_in}, 32'h1 << i);
    end
    in_case(8'h04, 17, 4'h0, 4'h2);
    in_case(8'h0C, 11, 4'h2, 4'h0);
    in_case(8'h0B, 2, 4'h0, 4'h0);
    in_case(8'h01, 2, 4'h2, 4'h2);
    apb(1'b1, 12'h00C, 32'h1);
    ext <= 24'h1 << 17;
    repeat (4) @(posedge pclk);
    #1;
    check("spi_in", {28'h0, spi_in}, 32'h2);
    $display("test inputs done");
    print_verdict();
  end
endmodule : ppr_router_tb
